// ---- src/npt_decoder.sv ----
/*
 * executes the nibble pair loads into accumulator and register b.
 * assumes instructions arrive one per cycle when insn_valid_i is high
 * and the caller holds off while busy_o is high; program memory data
 * are valid in the same cycle that rom_addr_o changes.
 */
//
// Function
// - timer one read: high nibble to b
// - timer one low nibble to acc, carry kept
// - timer two read: high nibble to b
// - timer two low nibble to acc, no skip
// - ext reg read: high nibble to b
// - table read: page operand, three cycles
`timescale 1ns/1ns
module npt_decoder
    import npt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // instruction stream
    input wire logic insn_valid_i,
    input wire logic [INSN_W-1:0] insn_i,
    input wire logic [PC_W-1:0] pc_i,
    // data sources
    input wire logic [7:0] timer_one_i,
    input wire logic [7:0] timer_two_i,
    input wire logic [7:0] ext_reg_i,
    input wire logic [INSN_W-1:0] rom_data_i,
    // results
    output logic [NIB_W-1:0] acc_o,
    output logic [NIB_W-1:0] reg_b_o,
    output logic load_o,
    output logic busy_o,
    output logic [PC_W-1:0] rom_addr_o,
    output logic [PC_W-1:0] pc_restore_o,
    output logic pc_restore_valid_o,
    output logic [SP_W-1:0] stack_pointer_o
);
    ////////////////////////////////////////////////////////////////////
    npt_state_e state_reg;
    logic [PC_W-1:0] stk_rdata;
    logic take;
    logic is_t1;
    logic is_t2;
    logic is_e;
    logic is_tbl;

    // decode only when not busy
    assign take = insn_valid_i && (state_reg == NPT_IDLE);
    assign is_t1 = take && (insn_i == OP_RD_T1);
    assign is_t2 = take && (insn_i == OP_RD_T2);
    assign is_e = take && (insn_i == OP_RD_E);
    assign is_tbl = take && (insn_i[9:6] == OP_TBL_HI);

    npt_stack u_stack (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_i(is_tbl),
        .addr_i(is_tbl ? stack_pointer_o + 3'h1 : stack_pointer_o),
        .wdata_i(pc_i),
        .rdata_o(stk_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // table read sequencer
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= NPT_IDLE;
        end else begin
            unique case (state_reg)
                NPT_IDLE: if (is_tbl) state_reg <= NPT_FETCH;
                NPT_FETCH: state_reg <= NPT_RESTORE;
                NPT_RESTORE: state_reg <= NPT_IDLE;
            endcase
        end
    end

    // stack pointer push and pop
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stack_pointer_o <= SP_RST;
        end else if (is_tbl) begin
            stack_pointer_o <= stack_pointer_o + 3'h1;
        end else if (state_reg == NPT_RESTORE) begin
            stack_pointer_o <= stack_pointer_o - 3'h1;
        end
    end

    // table address: page high, low three bits of b over accumulator low
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom_addr_o <= '0;
        end else if (is_tbl) begin
            rom_addr_o <= {insn_i[5:0], reg_b_o[2:0], acc_o};
        end
    end

    // restore of saved counter
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_restore_o <= '0;
            pc_restore_valid_o <= 1'b0;
        end else begin
            pc_restore_valid_o <= (state_reg == NPT_RESTORE);
            if (state_reg == NPT_RESTORE) begin
                pc_restore_o <= stk_rdata;
            end
        end
    end

    // busy while the table read runs
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= is_tbl || (state_reg == NPT_FETCH);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // nibble pair loads; carry and skip are not outputs here
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_o <= '0;
            reg_b_o <= '0;
            load_o <= 1'b0;
        end else begin
            load_o <= is_t1 || is_t2 || is_e || (state_reg == NPT_FETCH);
            if (is_t1) begin
                reg_b_o <= timer_one_i[7:4];
                acc_o <= timer_one_i[3:0];
            end else if (is_t2) begin
                reg_b_o <= timer_two_i[7:4];
                acc_o <= timer_two_i[3:0];
            end else if (is_e) begin
                reg_b_o <= ext_reg_i[7:4];
                acc_o <= ext_reg_i[3:0];
            end else if (state_reg == NPT_FETCH) begin
                reg_b_o <= rom_data_i[7:4];
                acc_o <= rom_data_i[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_timer_one_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_t1 |=> (reg_b_o == $past(timer_one_i[7:4])) && load_o)
        else $error("timer one high nibble not in b");
    chk_timer_one_acc: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_t1 |=> acc_o == $past(timer_one_i[3:0]))
        else $error("timer one low nibble not in acc");
    chk_timer_two_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_t2 |=> reg_b_o == $past(timer_two_i[7:4]))
        else $error("timer two high nibble not in b");
    chk_timer_two_acc: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_t2 |=> acc_o == $past(timer_two_i[3:0]) && !busy_o)
        else $error("timer two low nibble not in acc");
    chk_ext_reg_high: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_e |=> reg_b_o == $past(ext_reg_i[7:4]))
        else $error("ext reg high nibble not in b");
    chk_ext_reg_low: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_e |=> acc_o == $past(ext_reg_i[3:0]))
        else $error("ext reg low nibble not in acc");
    chk_table_three_cycles: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_tbl |=> busy_o ##1 (busy_o && load_o) ##1 !busy_o)
        else $error("table read not three cycles");
    chk_table_restore_pc: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_tbl |-> ##3 (pc_restore_valid_o && pc_restore_o == $past(pc_i, 3)
            && stack_pointer_o == $past(stack_pointer_o, 3)))
        else $error("saved counter not restored");

    ////////////////////////////////////////////////////////////////////
    // the word fetched from the table lands as a nibble pair
    chk_table_rom_word: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (state_reg == NPT_FETCH) |=>
            {reg_b_o, acc_o} == $past(rom_data_i[7:0]))
        else $error("table word not in acc and b");

    // page operand over low three bits of b and acc forms the table address
    chk_table_address: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_tbl |=> rom_addr_o == {$past(insn_i[5:0]),
            $past(reg_b_o[2:0]), $past(acc_o)})
        else $error("table address not page over b and acc");

    // one push per table read, made at the take edge
    chk_stack_push: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        is_tbl |=> (stack_pointer_o == $past(stack_pointer_o) + 3'h1)
            && busy_o)
        else $error("counter not pushed on table read");

    // an instruction offered in the restore cycle is refused
    chk_refused_busy: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (state_reg == NPT_RESTORE) |=> !load_o && $stable(acc_o)
            && $stable(reg_b_o))
        else $error("instruction taken while busy");

    // no load pulse without a taken load or a table fetch
    chk_no_stray_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !(is_t1 || is_t2 || is_e) && (state_reg != NPT_FETCH) |=> !load_o)
        else $error("load pulse without a load");

    // acc and b hold their pair between loads
    chk_pair_holds: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        !(is_t1 || is_t2 || is_e) && (state_reg != NPT_FETCH) |=>
            $stable(acc_o) && $stable(reg_b_o))
        else $error("acc or b changed without a load");
endmodule

// ---- src/npt_pkg.sv ----
/*
 * constants for the nibble pair transfer decoder: opcodes, widths,
 * cycle counts. assumes a 10-bit instruction word and 4-bit data path.
 */
package npt_pkg;
    localparam int unsigned INSN_W = 10;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned PAGE_W = 6;
    localparam int unsigned PCL_W = 7;
    localparam int unsigned PC_W = PAGE_W + PCL_W;
    localparam int unsigned STK_DEPTH = 8;
    localparam int unsigned SP_W = 3;
    // opcodes
    localparam logic [9:0] OP_RD_T1 = 10'h270;
    localparam logic [9:0] OP_RD_T2 = 10'h271;
    localparam logic [9:0] OP_RD_E = 10'h02A;
    localparam logic [3:0] OP_TBL_HI = 4'h2; // bits 9..6 of table read
    localparam int unsigned TBL_CYCLES = 3;
    localparam logic [SP_W-1:0] SP_RST = 3'h7;
    typedef enum logic [1:0] {NPT_IDLE, NPT_FETCH, NPT_RESTORE} npt_state_e;
endpackage

// ---- src/npt_stack.sv ----
/*
 * small return stack for the table read: registered read data.
 * assumes one write or nothing per cycle.
 */
`timescale 1ns/1ns
module npt_stack
    import npt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // access
    input wire logic wr_i,
    input wire logic [SP_W-1:0] addr_i,
    input wire logic [PC_W-1:0] wdata_i,
    output logic [PC_W-1:0] rdata_o
);
    logic [PC_W-1:0] mem_reg [STK_DEPTH];

    // write port
    always_ff @(posedge core_clk_i) begin
        if (wr_i) begin
            mem_reg[addr_i] <= wdata_i;
        end
    end

    // registered read
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_reg[addr_i];
        end
    end
endmodule

// ---- test/tb.sv ----
/*
 * self-checking bench for the nibble pair decoder: random and corner
 * loads. assumes the package constants and the decoder contract.
 */
`timescale 1ns/1ns
module tb;
    import npt_pkg::*;
    logic core_clk_i, rst_b_i, insn_valid_i, load_o, busy_o, pc_rv;
    logic [INSN_W-1:0] insn_i, rom_data_i;
    logic [PC_W-1:0] pc_i, rom_addr_o, pc_restore_o;
    logic [7:0] timer_one_i, timer_two_i, ext_reg_i, src;
    logic [NIB_W-1:0] acc_o, reg_b_o, exp_acc, exp_b;
    logic [SP_W-1:0] stack_pointer_o;
    logic [31:0] rnd;
    int err_total, n_compared;
    npt_decoder i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .insn_valid_i(insn_valid_i), .insn_i(insn_i), .pc_i(pc_i),
        .timer_one_i(timer_one_i), .timer_two_i(timer_two_i),
        .ext_reg_i(ext_reg_i), .rom_data_i(rom_data_i), .acc_o(acc_o),
        .reg_b_o(reg_b_o), .load_o(load_o), .busy_o(busy_o),
        .rom_addr_o(rom_addr_o), .pc_restore_o(pc_restore_o),
        .pc_restore_valid_o(pc_rv), .stack_pointer_o(stack_pointer_o));
    ////////////////////////////////////////////////////////////////////
    // 4 ns clock
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // galois shift register for stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    // expected table address: page over low three bits of b and acc
    function automatic logic [PC_W-1:0] tbl_addr(input logic [5:0] pg,
        input logic [7:0] ab);
        return {pg, ab[6:4], ab[3:0]};
    endfunction
    task automatic test_done;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one cycle: fresh sources, then drive an instruction or idle
    task automatic step(input logic vld, input logic [9:0] insn);
        rnd = lfsr(rnd);
        {ext_reg_i, timer_two_i, timer_one_i} = rnd[23:0];
        insn_valid_i = vld;
        insn_i = insn;
    endtask
    task automatic run_single(input int k);
        step(k < 3, k == 0 ? OP_RD_T1 : k == 1 ? OP_RD_T2 : OP_RD_E);
        src = k == 0 ? timer_one_i : k == 1 ? timer_two_i : ext_reg_i;
        if (k < 3) {exp_b, exp_acc} = src;
        @(negedge core_clk_i);
        check("reg_b", reg_b_o, exp_b);
        check("acc", acc_o, exp_acc);
        check("load", load_o, k < 3);
    endtask
    // table read with an instruction offered while busy
    task automatic run_table(input logic [5:0] pg);
        logic [SP_W-1:0] sp_push;
        logic [PC_W-1:0] pc;
        sp_push = SP_RST + 3'h1;
        step(1'b1, {OP_TBL_HI, pg});
        rom_data_i = rnd[9:0];
        pc = rnd[30:18];
        pc_i = pc;
        @(negedge core_clk_i);
        check("busy", busy_o, 1'b1);
        check("rom_addr", rom_addr_o, tbl_addr(pg, {exp_b, exp_acc}));
        check("sp", stack_pointer_o, sp_push);
        insn_i = OP_RD_T2;
        pc_i = ~pc;
        {exp_b, exp_acc} = rom_data_i[7:0];
        @(negedge core_clk_i);
        check("tbl", {reg_b_o, acc_o}, {exp_b, exp_acc});
        check("tbl_load", {load_o, busy_o}, 2'h3);
        step(1'b1, OP_RD_T1);
        @(negedge core_clk_i);
        check("tbl_end", {busy_o, pc_rv, load_o}, 3'h2);
        check("tbl_hold", {reg_b_o, acc_o}, {exp_b, exp_acc});
        check("pc_back", pc_restore_o, pc);
        check("sp_back", stack_pointer_o, SP_RST);
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence: reset, corners, random mix
    initial begin
        rnd = 32'h74A1;
        err_total = 0;
        n_compared = 0;
        rst_b_i = 1'b0;
        pc_i = 13'h0000;
        rom_data_i = 10'h000;
        step(1'b0, 10'h000);
        repeat (12) @(negedge core_clk_i);
        check("rst", {acc_o, reg_b_o, load_o, busy_o, pc_rv},
            11'h000);
        check("rst_sp", stack_pointer_o, SP_RST);
        rst_b_i = 1'b1;
        {exp_b, exp_acc} = 8'h00;
        run_table(6'h00);
        for (int k = 0; k < 3; k++) run_single(k);
        run_table(6'h3F);
        run_table(6'h15);
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr(rnd);
            if (rnd[2:0] == 3'h3) run_table(rnd[8:3]);
            else run_single(rnd[2:0] > 3'h3 ? 3 : int'(rnd[1:0]));
        end
        test_done();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        $display("Error timeout");
        test_done();
    end
endmodule
